// *** hw/hbpc_top.sv ***
// Host bus pin control: select decode, ready, straps, serial memory load, APB registers
//
// Notes on behaviour
// R01 - Select output low when qualifier low and upper address matches base high byte.
// R02 - Select output is pure combinational decode of address and qualifier.
// R03 - Host drives read strobe low for the whole asynchronous read.
// R04 - Host drives write strobe low for the whole asynchronous write.
// R05 - Async ready may be held low to stretch an access; no host clock used.
// R06 - Sync mode: host asserts cycle phase after addressing to start command phase.
// R07 - Burst mode, 32-bit only: cycle phase high for reads, low for writes.
// R08 - Bus mode strap low or floating selects synchronous operation.
// R09 - Bus mode strap high selects 8/16-bit asynchronous or burst operation.
// R10 - Memory present strap high uses serial memory; low skips loading.
// R11 - Serial clock period 4 us at 25 MHz setting, 800 ns at 125 MHz.
// R12 - Data shifted out on serial output pin, memory data taken on serial input.
// R13 - Without memory, serial input strap: low 8-bit, high 16-bit, ignored for 32-bit.
// R14 - Host drives write/read select high for writes, low for reads.
// R15 - Address ignored for decode while qualifier is high.
// R16 - With latching, capture address and qualifier on latch strobe rising edge.
// R17 - Power-down while sleep input low; normal while high or floating.
// R18 - In 8-bit mode lane 1 enable is inverse of lane 0; pin ignored.
// R19 - Straps sampled at reset release and kept until next reset.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module hbpc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_clock,
	input wire logic [15:1] address_in,
	input wire logic address_qualifier_n,
	input wire logic address_latch_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic cycle_phase_n,
	input wire logic sync_write_not_read,
	input wire logic byte_lane0_enable_n,
	input wire logic byte_lane1_enable_n,
	input wire logic sync_bus_mode_strap,
	input wire logic eeprom_present_strap,
	input wire logic eeprom_serial_in,
	input wire logic chip_sleep_n,
	output logic local_device_select_n,
	output logic async_ready_out,
	output logic async_ready_oe_n,
	output logic eeprom_select,
	output logic eeprom_serial_clock,
	output logic eeprom_serial_out,
	output logic byte_lane0_internal_n,
	output logic byte_lane1_internal_n,
	output logic chip_powered_down,
	output hbpc_pkg::hbpc_strap_t strap_cfg
);
	// Pin synchronisers, pclk side: first stage read only by second stage
	localparam int NSYNC = 24;
	logic [NSYNC-1:0] pin_raw, pin_s1, pin_s2;
	assign pin_raw = {address_in[15:1], address_qualifier_n, address_latch_strobe_n,
		read_strobe_n, write_strobe_n, byte_lane0_enable_n, byte_lane1_enable_n,
		sync_bus_mode_strap, eeprom_present_strap, chip_sleep_n};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= {NSYNC{1'b1}};
			pin_s2 <= {NSYNC{1'b1}};
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end
	logic [15:1] s_addr;
	logic s_qual_n, s_latch_n, s_rd_n, s_wr_n, s_be0_n, s_be1_n;
	logic s_mode_strap, s_ee_strap, s_sleep_n;
	assign {s_addr, s_qual_n, s_latch_n, s_rd_n, s_wr_n, s_be0_n, s_be1_n,
		s_mode_strap, s_ee_strap, s_sleep_n} = pin_s2;

	// Serial input sync kept apart: it is both a strap and memory data
	logic ee_in_s1, ee_in_s2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ee_in_s1 <= 1'b0;
			ee_in_s2 <= 1'b0;
		end else begin
			ee_in_s1 <= eeprom_serial_in;
			ee_in_s2 <= ee_in_s1;
		end
	end

	// Registers
	logic [15:0] base_addr, next_base_addr;
	logic [1:0] speed, next_speed;
	logic latch_en, next_latch_en;
	logic [3:0] wait_cycles, next_wait_cycles;
	logic ee_start_sw, next_ee_start_sw;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic [15:0] ee_data;
	logic ee_busy;
	logic [15:0] sync_count;
	logic last_sync_write;
	logic ee_loaded;

	logic wr_en, mapped;
	assign wr_en = psel & penable & pready & pwrite;
	assign mapped = (paddr == hbpc_pkg::OFS_BASE) | (paddr == hbpc_pkg::OFS_CTRL) |
		(paddr == hbpc_pkg::OFS_STATUS) | (paddr == hbpc_pkg::OFS_EEDATA) |
		(paddr == hbpc_pkg::OFS_SYNCCNT);

	always_comb begin
		next_base_addr = base_addr;
		next_speed = speed;
		next_latch_en = latch_en;
		next_wait_cycles = wait_cycles;
		next_ee_start_sw = 1'b0;
		// One-cycle answer: pready rises in the access phase only
		next_pready = psel & ~penable;
		next_pslverr = psel & ~penable & ~mapped;
		next_prdata = 32'h0;
		if (wr_en && paddr == hbpc_pkg::OFS_BASE) begin
			if (pstrb[0]) next_base_addr[7:0] = pwdata[7:0];
			if (pstrb[1]) next_base_addr[15:8] = pwdata[15:8];
		end
		if (wr_en && paddr == hbpc_pkg::OFS_CTRL && pstrb[0]) begin
			next_speed = pwdata[hbpc_pkg::CTRL_SPEED_LSB +: 2];
			next_latch_en = pwdata[hbpc_pkg::CTRL_LATCH_EN];
			next_ee_start_sw = pwdata[hbpc_pkg::CTRL_EE_START];
			next_wait_cycles = pwdata[hbpc_pkg::CTRL_WAIT_LSB +: hbpc_pkg::CTRL_WAIT_W];
		end
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				hbpc_pkg::OFS_BASE: next_prdata = {16'h0, base_addr};
				hbpc_pkg::OFS_CTRL: next_prdata = {24'h0, wait_cycles, 1'b0, latch_en, speed};
				hbpc_pkg::OFS_STATUS: next_prdata = {24'h0, last_sync_write, ee_loaded,
					ee_busy, chip_powered_down, 1'b0, strap_cfg};
				hbpc_pkg::OFS_EEDATA: next_prdata = {16'h0, ee_data};
				hbpc_pkg::OFS_SYNCCNT: next_prdata = {16'h0, sync_count};
				default: next_prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_addr <= hbpc_pkg::BASE_RESET;
			speed <= hbpc_pkg::SPEED_RESET;
			latch_en <= 1'b0;
			wait_cycles <= hbpc_pkg::WAIT_RESET;
			ee_start_sw <= 1'b0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			base_addr <= next_base_addr;
			speed <= next_speed;
			latch_en <= next_latch_en;
			wait_cycles <= next_wait_cycles;
			ee_start_sw <= next_ee_start_sw;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Straps taken once, a few cycles after release so the syncs hold pin levels
	logic [1:0] strap_wait, next_strap_wait;
	logic strap_taken, next_strap_taken;
	hbpc_pkg::hbpc_strap_t next_strap_cfg;
	logic ee_auto_start;
	always_comb begin
		next_strap_wait = strap_wait;
		next_strap_taken = strap_taken;
		next_strap_cfg = strap_cfg;
		ee_auto_start = 1'b0;
		if (!strap_taken) begin
			if (strap_wait != hbpc_pkg::STRAP_DELAY) begin
				next_strap_wait = strap_wait + 1'b1;
			end else begin
				next_strap_taken = 1'b1; // R19
				next_strap_cfg.sync_mode = ~s_mode_strap; // R08 R09
				next_strap_cfg.eeprom_present = s_ee_strap; // R10
				// Width strap only counts with no memory fitted
				next_strap_cfg.width16 = ~s_ee_strap & ee_in_s2; // R13
				ee_auto_start = s_ee_strap; // R10
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_wait <= 2'h0;
			strap_taken <= 1'b0;
			strap_cfg <= '0;
		end else begin
			strap_wait <= next_strap_wait;
			strap_taken <= next_strap_taken;
			strap_cfg <= next_strap_cfg;
		end
	end

	// Serial memory loads only when present
	logic ee_busy_d;
	hbpc_eeprom u_eeprom (
		.pclk(pclk),
		.presetn(presetn),
		.start(ee_auto_start | (ee_start_sw & strap_cfg.eeprom_present & ~ee_busy)), // R10
		.speed(speed),
		.serial_in(ee_in_s2),
		.select(eeprom_select),
		.serial_clock(eeprom_serial_clock),
		.serial_out(eeprom_serial_out),
		.busy(ee_busy),
		.data(ee_data)
	);

	// Address latch on strobe rising edge
	logic latch_d, next_latch_d;
	logic [15:4] lat_addr, next_lat_addr;
	logic lat_qual_n, next_lat_qual_n;
	always_comb begin
		next_latch_d = s_latch_n;
		next_lat_addr = lat_addr;
		next_lat_qual_n = lat_qual_n;
		if (s_latch_n && !latch_d) begin
			next_lat_addr = s_addr[15:4]; // R16
			next_lat_qual_n = s_qual_n; // R16
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_d <= 1'b1;
			lat_addr <= '0;
			lat_qual_n <= 1'b1;
			ee_busy_d <= 1'b0;
			ee_loaded <= 1'b0;
		end else begin
			latch_d <= next_latch_d;
			lat_addr <= next_lat_addr;
			lat_qual_n <= next_lat_qual_n;
			ee_busy_d <= ee_busy;
			ee_loaded <= ee_loaded | (ee_busy_d & ~ee_busy);
		end
	end

	// Decode has no flop in its path when latching is off; speed over glitch safety
	always_comb begin
		if (latch_en) begin
			local_device_select_n = ~(~lat_qual_n & (lat_addr[15:8] == base_addr[15:8]));
		end else begin
			local_device_select_n = ~(~address_qualifier_n &
				(address_in[15:8] == base_addr[15:8])); // R01 R02 R15
		end
	end

	// Ready stretch: counts from strobe start, pclk only, never the host clock
	logic strobe_act, strobe_d, sel_s;
	logic [3:0] wait_cnt, next_wait_cnt;
	logic next_ready_low, ready_low;
	assign sel_s = latch_en ? ~lat_qual_n & (lat_addr[15:8] == base_addr[15:8]) :
		~s_qual_n & (s_addr[15:8] == base_addr[15:8]);
	assign strobe_act = ~s_rd_n | ~s_wr_n; // R03 R04
	always_comb begin
		next_wait_cnt = wait_cnt;
		next_ready_low = ready_low;
		if (strobe_act && !strobe_d && sel_s && !strap_cfg.sync_mode &&
			wait_cycles != 4'h0) begin
			next_wait_cnt = wait_cycles;
			next_ready_low = 1'b1; // R05
		end else if (ready_low) begin
			next_wait_cnt = wait_cnt - 1'b1;
			if (wait_cnt == 4'h1 || !strobe_act) begin
				next_ready_low = 1'b0; // R05
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_d <= 1'b0;
			wait_cnt <= 4'h0;
			ready_low <= 1'b0;
			async_ready_out <= 1'b0;
			async_ready_oe_n <= 1'b1;
		end else begin
			strobe_d <= strobe_act;
			wait_cnt <= next_wait_cnt;
			ready_low <= next_ready_low;
			async_ready_out <= 1'b0;
			async_ready_oe_n <= ~next_ready_low; // R05
		end
	end

	// Byte lanes and power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_lane0_internal_n <= 1'b1;
			byte_lane1_internal_n <= 1'b1;
			chip_powered_down <= 1'b0;
		end else begin
			byte_lane0_internal_n <= s_be0_n;
			// 8-bit: asynchronous mode with narrow width strap
			byte_lane1_internal_n <= (!strap_cfg.sync_mode && !strap_cfg.width16) ?
				~s_be0_n : s_be1_n; // R18
			chip_powered_down <= ~s_sleep_n; // R17
		end
	end

	// Link domain: command phase seen on host bus clock
	logic [3:0] lk_s1, lk_s2;
	logic lk_cyc_d, lk_tog, lk_dir;
	always_ff @(posedge bus_clock or negedge presetn) begin
		if (!presetn) begin
			// Idle pin levels, so no false command edge follows reset
			lk_s1 <= 4'ha;
			lk_s2 <= 4'ha;
			lk_cyc_d <= 1'b1;
			lk_tog <= 1'b0;
			lk_dir <= 1'b0;
		end else begin
			lk_s1 <= {cycle_phase_n, sync_write_not_read, local_device_select_n,
				strap_cfg.sync_mode};
			lk_s2 <= lk_s1;
			lk_cyc_d <= lk_s2[3];
			if (!lk_s2[3] && lk_cyc_d && !lk_s2[1] && lk_s2[0]) begin
				lk_dir <= lk_s2[2]; // R06 R14
				lk_tog <= ~lk_tog;
			end
		end
	end

	// Toggle crossing back; direction is stable by the time the toggle lands
	logic tg_s1, tg_s2, tg_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tg_s1 <= 1'b0;
			tg_s2 <= 1'b0;
			tg_d <= 1'b0;
			sync_count <= 16'h0;
			last_sync_write <= 1'b0;
		end else begin
			tg_s1 <= lk_tog;
			tg_s2 <= tg_s1;
			tg_d <= tg_s2;
			if (tg_s2 != tg_d) begin
				sync_count <= sync_count + 1'b1;
				last_sync_write <= lk_dir;
			end
		end
	end
endmodule : hbpc_top
`default_nettype wire

// *** hw/hbpc_pkg.sv ***
// Package: constants, types and register map for the host bus pin control block
package hbpc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_BASE = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_EEDATA = 8'h0c;
	localparam logic [7:0] OFS_SYNCCNT = 8'h10;
	// Control field positions
	localparam int CTRL_SPEED_LSB = 0;
	localparam int CTRL_LATCH_EN = 2;
	localparam int CTRL_EE_START = 3;
	localparam int CTRL_WAIT_LSB = 4;
	localparam int CTRL_WAIT_W = 4;
	// Values after reset, and the fast speed code
	localparam logic [15:0] BASE_RESET = 16'h0300;
	localparam logic [1:0] SPEED_RESET = 2'h3;
	localparam logic [1:0] SPEED_FAST = 2'h0;
	localparam logic [3:0] WAIT_RESET = 4'h0;
	// Clock and serial clock timing
	localparam int PCLK_PERIOD_NS = 4;
	localparam int EE_PERIOD_SLOW_NS = 4000;
	localparam int EE_PERIOD_FAST_NS = 800;
	localparam int EE_HALF_SLOW = EE_PERIOD_SLOW_NS / (2 * PCLK_PERIOD_NS);
	localparam int EE_HALF_FAST = EE_PERIOD_FAST_NS / (2 * PCLK_PERIOD_NS);
	localparam int EE_DIV_W = 10;
	// Serial read frame: start, opcode, six address bits, then sixteen data bits
	localparam logic [8:0] EE_READ_CMD = 9'h180;
	localparam int EE_CMD_BITS = 9;
	localparam int EE_DATA_BITS = 16;
	// Cycles after reset release before straps are taken
	localparam logic [1:0] STRAP_DELAY = 2'h3;

	typedef struct packed {
		logic sync_mode;
		logic eeprom_present;
		logic width16;
	} hbpc_strap_t;

	typedef enum logic [1:0] {
		HBPC_EE_IDLE,
		HBPC_EE_CMD,
		HBPC_EE_DATA
	} hbpc_ee_state_t;
endpackage : hbpc_pkg

// *** hw/hbpc_eeprom.sv ***
// Serial configuration memory reader with selectable clock period
`timescale 1ns/1ns
`default_nettype none
module hbpc_eeprom (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [1:0] speed,
	input wire logic serial_in,
	output logic select,
	output logic serial_clock,
	output logic serial_out,
	output logic busy,
	output logic [15:0] data
);
	hbpc_pkg::hbpc_ee_state_t state, next_state;
	logic [hbpc_pkg::EE_DIV_W-1:0] div, next_div, half;
	logic [4:0] bits, next_bits;
	logic [8:0] cmd, next_cmd;
	logic [15:0] next_data;
	logic next_select, next_clock, next_out;

	// Period follows the internal bus speed field
	assign half = (speed == hbpc_pkg::SPEED_FAST) ?
		hbpc_pkg::EE_DIV_W'(hbpc_pkg::EE_HALF_FAST - 1) :
		hbpc_pkg::EE_DIV_W'(hbpc_pkg::EE_HALF_SLOW - 1); // R11

	always_comb begin
		next_state = state;
		next_div = div;
		next_bits = bits;
		next_cmd = cmd;
		next_data = data;
		next_select = select;
		next_clock = serial_clock;
		next_out = serial_out;
		unique case (state)
			hbpc_pkg::HBPC_EE_IDLE: begin
				next_clock = 1'b0;
				if (start) begin
					next_state = hbpc_pkg::HBPC_EE_CMD;
					next_select = 1'b1;
					next_cmd = hbpc_pkg::EE_READ_CMD;
					next_bits = 5'(hbpc_pkg::EE_CMD_BITS);
					next_div = half;
					next_out = hbpc_pkg::EE_READ_CMD[8]; // R12
				end
			end
			hbpc_pkg::HBPC_EE_CMD, hbpc_pkg::HBPC_EE_DATA: begin
				if (div != '0) begin
					next_div = div - 1'b1;
				end else begin
					next_div = half;
					next_clock = ~serial_clock;
					if (serial_clock) begin
						// Falling edge: move to the next bit
						next_bits = bits - 1'b1;
						if (state == hbpc_pkg::HBPC_EE_CMD) begin
							next_cmd = {cmd[7:0], 1'b0};
							next_out = cmd[7]; // R12
							if (bits == 5'h01) begin
								next_state = hbpc_pkg::HBPC_EE_DATA;
								next_bits = 5'(hbpc_pkg::EE_DATA_BITS);
								next_out = 1'b0;
							end
						end else if (bits == 5'h01) begin
							next_state = hbpc_pkg::HBPC_EE_IDLE;
							next_select = 1'b0;
						end
					end else if (state == hbpc_pkg::HBPC_EE_DATA) begin
						// Rising edge: take the memory's output bit
						next_data = {data[14:0], serial_in}; // R12
					end
				end
			end
			default: next_state = hbpc_pkg::HBPC_EE_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= hbpc_pkg::HBPC_EE_IDLE;
			div <= '0;
			bits <= '0;
			cmd <= '0;
			data <= '0;
			select <= 1'b0;
			serial_clock <= 1'b0;
			serial_out <= 1'b0;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			div <= next_div;
			bits <= next_bits;
			cmd <= next_cmd;
			data <= next_data;
			select <= next_select;
			serial_clock <= next_clock;
			serial_out <= next_out;
			busy <= (next_state != hbpc_pkg::HBPC_EE_IDLE);
		end
	end
endmodule : hbpc_eeprom
`default_nettype wire

// *** tb/hbpc_monitor.sv ***
// Checker: port-level assertions for the host bus pin control block
`timescale 1ns/1ns
`default_nettype none
module hbpc_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:1] address_in,
	input wire logic address_qualifier_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chip_sleep_n,
	input wire logic local_device_select_n,
	input wire logic async_ready_out,
	input wire logic async_ready_oe_n,
	input wire logic eeprom_select,
	input wire logic eeprom_serial_clock,
	input wire logic eeprom_serial_out,
	input wire logic byte_lane0_internal_n,
	input wire logic byte_lane1_internal_n,
	input wire logic chip_powered_down,
	input wire hbpc_pkg::hbpc_strap_t strap_cfg
);
	logic [7:0] base_hi, next_base_hi;
	logic latch_en, next_latch_en;
	logic [3:0] age, next_age;
	// Shadow of base and latch enable, so decode is judged without seeing inside
	always_comb begin
		next_base_hi = base_hi;
		next_latch_en = latch_en;
		next_age = (age == 4'hf) ? age : age + 4'h1;
		if (psel && penable && pready && pwrite) begin
			if (paddr == hbpc_pkg::OFS_BASE && pstrb[1]) next_base_hi = pwdata[15:8];
			if (paddr == hbpc_pkg::OFS_CTRL && pstrb[0])
				next_latch_en = pwdata[hbpc_pkg::CTRL_LATCH_EN];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_hi <= hbpc_pkg::BASE_RESET[15:8];
			latch_en <= 1'b0;
			age <= 4'h0;
		end else begin
			base_hi <= next_base_hi;
			latch_en <= next_latch_en;
			age <= next_age;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_sck_hold;
		$stable(eeprom_serial_clock) [*8];
	endsequence
	a_apb_answer: assert property (s_setup |=> pready && penable)
		else $error("no answer one cycle after setup");
	a_apb_unmapped: assert property (s_setup ##0 paddr > hbpc_pkg::OFS_SYNCCNT |=> pslverr)
		else $error("unmapped access without error");
	a_select_decode: assert property (!latch_en |-> local_device_select_n ==
		!(!address_qualifier_n && address_in[15:8] == base_hi)) else $error("select decode wrong");
	a_stretch_mode: assert property (!async_ready_oe_n |-> !strap_cfg.sync_mode
		&& !async_ready_out) else $error("ready stretched outside async mode");
	a_stretch_cause: assert property ($fell(async_ready_oe_n) |->
		!(read_strobe_n && write_strobe_n)) else $error("ready stretched without strobe");
	a_lane_narrow: assert property (age == 4'hf && !strap_cfg.sync_mode && !strap_cfg.width16
		|-> byte_lane1_internal_n == !byte_lane0_internal_n) else $error("lane one not derived");
	a_sleep_enter: assert property ($fell(chip_sleep_n) |-> ##[1:6] chip_powered_down)
		else $error("power-down not entered");
	a_sck_gated: assert property ($rose(eeprom_serial_clock) |-> eeprom_select)
		else $error("serial clock outside a load");
	a_sck_half: assert property ($rose(eeprom_serial_clock) |=> s_sck_hold)
		else $error("serial clock high too short");
	a_sout_steady: assert property (eeprom_serial_clock && $past(eeprom_serial_clock)
		|-> $stable(eeprom_serial_out)) else $error("serial out moved while clock high");
endmodule : hbpc_monitor
`default_nettype wire

// *** tb/hbpc_host_model.sv ***
// Host processor model: drives the host bus pins from its own bus clock
`timescale 1ns/1ns
`default_nettype none
module hbpc_host_model (
	output logic bus_clock,
	output logic [15:1] address_in,
	output logic address_qualifier_n,
	output logic address_latch_strobe_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic cycle_phase_n,
	output logic sync_write_not_read
);
	initial begin
		{address_in, address_qualifier_n, address_latch_strobe_n} = {15'h0, 2'b11};
		{read_strobe_n, write_strobe_n, cycle_phase_n, sync_write_not_read} = 4'he;
		bus_clock = 1'b0;
		// Offset keeps the two clocks out of step
		#1;
		forever #3 bus_clock = ~bus_clock;
	end
	task put(input logic [15:0] a, input logic q);
		@(posedge bus_clock);
		address_in <= a[15:1];
		address_qualifier_n <= q;
	endtask : put
	task latch();
		@(posedge bus_clock);
		address_latch_strobe_n <= 1'b0;
		@(posedge bus_clock);
		address_latch_strobe_n <= 1'b1;
	endtask : latch
	task strobe(input logic rd_n, input logic wr_n);
		@(posedge bus_clock);
		read_strobe_n <= rd_n;
		write_strobe_n <= wr_n;
	endtask : strobe
	task cyc(input logic w);
		@(posedge bus_clock);
		sync_write_not_read <= w;
		cycle_phase_n <= 1'b0;
		@(posedge bus_clock);
		cycle_phase_n <= 1'b1;
	endtask : cyc
	task burst(input logic w, input int len);
		@(posedge bus_clock);
		cycle_phase_n <= ~w;
		repeat (len) @(posedge bus_clock);
		cycle_phase_n <= 1'b1;
	endtask : burst
endmodule : hbpc_host_model
`default_nettype wire

// *** tb/testbench.sv ***
// Testbench: straps, select decode, ready stretch, serial memory load, registers
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [3:0] pstrb = 4'h3;
	logic pready, pslverr, local_device_select_n, async_ready_out, async_ready_oe_n;
	logic eeprom_select, eeprom_serial_clock, eeprom_serial_out, chip_powered_down;
	logic byte_lane0_internal_n, byte_lane1_internal_n, mem_bit = 0;
	logic byte_lane0_enable_n = 1, byte_lane1_enable_n = 1, chip_sleep_n = 1;
	logic sync_bus_mode_strap = 1, eeprom_present_strap = 0, strap_si = 0;
	hbpc_pkg::hbpc_strap_t strap_cfg;
	wire logic bus_clock, address_qualifier_n, address_latch_strobe_n, read_strobe_n;
	wire logic write_strobe_n, cycle_phase_n, sync_write_not_read, eeprom_serial_in;
	wire logic [15:1] address_in;
	int mismatches = 0, n_checks = 0, rises = 0, per = 0, n;
	time t_last = 0;
	logic [24:0] caps = 0;
	localparam logic [15:0] PAT = 16'ha5c3;
	assign eeprom_serial_in = eeprom_present_strap ? mem_bit : strap_si;
	always #2 pclk = ~pclk;
	hbpc_top i_dut (.*);
	hbpc_host_model i_host (.*);
	always @(posedge eeprom_serial_clock) if (eeprom_select === 1'b1) begin
		rises++;
		caps <= {caps[23:0], eeprom_serial_out};
		per = int'($time - t_last);
		t_last = $time;
	end
	// Memory answers on falling edges; released, the line falls to its pull-down
	always @(negedge eeprom_serial_clock)
		mem_bit <= (rises >= 9 && rises < 25) ? PAT[24 - rises] : 1'b0;
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rst(input logic sb, input logic ep, input logic si);
		{presetn, sync_bus_mode_strap, eeprom_present_strap, strap_si} <= {1'b0, sb, ep, si};
		rises = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask : rst
	task wait_load();
		while (eeprom_select !== 1'b0) @(posedge pclk);
	endtask : wait_load
	task wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	initial begin
		for (int i = 0; i < 2; i++) begin
			rst(1'b1, 1'b0, i == 0);
			// Pins move after sampling; the taken values must not
			{sync_bus_mode_strap, strap_si} <= {1'b0, ~strap_si};
			apb(1'b0, hbpc_pkg::OFS_STATUS, 32'h0);
			chk("status", q & 32'hff, {31'h0, i == 0});
			chk("strap", strap_cfg, {31'h0, i == 0});
			sync_bus_mode_strap <= 1'b1;
		end
		apb(1'b0, hbpc_pkg::OFS_BASE, 32'h0);
		chk("base", q, 32'h300);
		apb(1'b0, hbpc_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", q, 32'h3);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", {q[30:0], err}, 32'h1);
		apb(1'b1, hbpc_pkg::OFS_BASE, 32'h400);
		for (int k = 0; k < 3; k++) begin
			i_host.put(k == 2 ? 16'h0500 : 16'h0400, k == 1);
			repeat (3) @(posedge pclk);
			chk("select", local_device_select_n, k != 0);
		end
		$display("test straps and decode done");
		{byte_lane0_enable_n, byte_lane1_enable_n} <= 2'b00;
		repeat (6) @(posedge pclk);
		chk("lanes", {byte_lane0_internal_n, byte_lane1_internal_n}, 2'b01);
		byte_lane0_enable_n <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("lanes", {byte_lane0_internal_n, byte_lane1_internal_n}, 2'b10);
		apb(1'b1, hbpc_pkg::OFS_CTRL, 32'h43);
		i_host.put(16'h0400, 1'b0);
		for (int s = 0; s < 2; s++) begin
			i_host.strobe(s != 0, s == 0);
			n = 0;
			repeat (30) begin
				@(posedge pclk);
				n += (async_ready_oe_n === 1'b0);
			end
			i_host.strobe(1'b1, 1'b1);
			chk("stretch", n, 4);
			repeat (10) @(posedge pclk);
		end
		apb(1'b1, hbpc_pkg::OFS_CTRL, 32'h07);
		i_host.put(16'h0400, 1'b0);
		i_host.latch();
		i_host.put(16'h0500, 1'b0);
		repeat (10) @(posedge pclk);
		chk("latched", local_device_select_n, 1'b0);
		i_host.latch();
		repeat (10) @(posedge pclk);
		chk("latched", local_device_select_n, 1'b1);
		apb(1'b1, hbpc_pkg::OFS_CTRL, 32'h03);
		chip_sleep_n <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(1'b0, hbpc_pkg::OFS_STATUS, 32'h0);
		chk("sleep", {chip_powered_down, q[4]}, 2'b11);
		chip_sleep_n <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("wake", chip_powered_down, 1'b0);
		$display("test async host pins done");
		rst(1'b0, 1'b1, 1'b0);
		apb(1'b0, hbpc_pkg::OFS_STATUS, 32'h0);
		chk("status", q[2:0], 3'b110);
		for (int f = 0; f < 2; f++) begin
			wait_load();
			chk("command", caps[24:16], 9'h180);
			chk("period", per, f ? 800 : 4000);
			apb(1'b0, hbpc_pkg::OFS_EEDATA, 32'h0);
			chk("memdata", q, PAT);
			rises = 0;
			apb(1'b1, hbpc_pkg::OFS_CTRL, 32'h08);
			repeat (4) @(posedge pclk);
		end
		i_host.put(16'h0300, 1'b0);
		for (int w = 1; w >= 0; w--) begin
			i_host.cyc(w == 1);
			repeat (20) @(posedge pclk);
			apb(1'b0, hbpc_pkg::OFS_STATUS, 32'h0);
			chk("direction", q[7], w == 1);
		end
		// A read burst keeps cycle phase high, so no command may be counted
		i_host.burst(1'b0, 4);
		repeat (20) @(posedge pclk);
		apb(1'b0, hbpc_pkg::OFS_SYNCCNT, 32'h0);
		chk("count", q, 32'h2);
		$display("test sync mode and memory load done");
		wrap_up();
	end
	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end
endmodule : testbench
bind hbpc_top hbpc_monitor i_mon (.*);
`default_nettype wire
